/* File: hdl/bcu_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef BCU_MAP_SVH
`define BCU_MAP_SVH
`define BCU_OFF_CTRL      4'h0
`define BCU_OFF_CMD       4'h1
`define BCU_OFF_IRQSTAT   4'h2
`define BCU_OFF_IRQMASK   4'h3
`define BCU_OFF_STATUS    4'h4
`define BCU_BIT_VGA       19
`define BCU_BIT_RSVD      20
`define BCU_BIT_MABORT    21
`define BCU_BIT_SECRST    22
`define BCU_BIT_FB2B      23
`define BCU_BIT_PTOSEL    24
`define BCU_BIT_TOSTAT    26
`define BCU_BIT_IOEN      0
`define BCU_BIT_MEMEN     1
`define BCU_BIT_SERREN    8
`define BCU_CTRL_WMASK    32'h01E8_0000
`define BCU_CMD_WMASK     32'h0000_0103
`define BCU_RST_CTRL      32'h0000_0000
`define BCU_TO_LONG_LOG2  15
`define BCU_TO_SHORT_LOG2 10
`define BCU_ALL_ONES      32'hFFFF_FFFF
`define BCU_VGA_MEM_LO    32'h000A_0000
`define BCU_VGA_MEM_HI    32'h000B_FFFF
`define BCU_VGA_IO1_LO    10'h3B0
`define BCU_VGA_IO1_HI    10'h3BB
`define BCU_VGA_IO2_LO    10'h3C0
`define BCU_VGA_IO2_HI    10'h3DF
`define BCU_IRQ_TIMEOUT   0
`define BCU_IRQ_MABORT    1
`endif

/* File: hdl/bcu_pkg.sv */
// Types shared by the bridge control block
package bcu_pkg;
    typedef enum logic [1:0] {
        BCU_TO_IDLE,
        BCU_TO_RUN,
        BCU_TO_DONE
    } bcu_to_state_t;

    typedef struct packed {
        bcu_to_state_t state;
        logic [15:0]   count;
        logic          expired;
    } bcu_timer_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] cmd;
        logic [1:0]  irqStat;
        logic [1:0]  irqMask;
        logic        toStatus;
        logic [31:0] readData;
        logic        readValid;
        logic        fwdDown;
        logic        claimUp;
        logic        daTargetAbort;
        logic        daAllOnes;
        logic        primSerr;
    } bcu_regs_t;
endpackage : bcu_pkg

/* File: hdl/bcu_timeout.sv */
// Primary master time-out counter for queued delayed completions
`include "bcu_map.svh"
module bcu_timeout
    import bcu_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic headValid,
    input  wire logic retrySeen,
    input  wire logic shortSel,
    output logic      expired
);
    bcu_timer_t st_r;
    bcu_timer_t st_nxt;
    logic [15:0] limit;

    // Time-out length from the select bit
    // RL14 length select
    assign limit = shortSel ? 16'((1 << `BCU_TO_SHORT_LOG2) - 1)
                            : 16'((1 << `BCU_TO_LONG_LOG2) - 1);
    assign expired = st_r.expired;

    // Counter state machine
    always_comb begin
        st_nxt = st_r;
        st_nxt.expired = 1'b0;
        unique case (st_r.state)
            BCU_TO_IDLE: begin
                st_nxt.count = 16'h0000;
                // RL12 start at head
                if (headValid && !retrySeen) begin
                    st_nxt.state = BCU_TO_RUN;
                end
            end
            BCU_TO_RUN: begin
                // RL18 reload on retry
                if (retrySeen || !headValid) begin
                    st_nxt.state = BCU_TO_IDLE;
                    st_nxt.count = 16'h0000;
                // RL13 discard on expiry
                end else if (st_r.count >= limit) begin
                    st_nxt.expired = 1'b1;
                    st_nxt.state   = BCU_TO_DONE;
                end else begin
                    st_nxt.count = st_r.count + 16'h0001;
                end
            end
            BCU_TO_DONE: begin
                // Wait for queue to drop the entry
                if (!headValid) begin
                    st_nxt.state = BCU_TO_IDLE;
                end
            end
        endcase
    end

    // RL18 primary reset clears
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= '{state: BCU_TO_IDLE, count: 16'h0000, expired: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule : bcu_timeout

/* File: hdl/bcu_bridge_ctrl.sv */
// Bridge control upper bits, decode, abort policy and bus slave
// Notes on behaviour
// RL1: VGA I/O decode ignores bits 15:10, needs bits 31:16 zero.
// RL2: VGA forwarding needs both I/O and memory space enables.
// RL3: VGA ranges seen on secondary bus are never claimed upstream; the code excludes them only while VGA enable (bit 19) is set.
// RL4: Bit 20 reads zero, writes ignored.
// RL5: Policy clear: delayed aborts complete, reads give all ones, no SERR.
// RL6: Policy set: delayed transaction ends with target abort.
// RL7: Policy set: aborted posted write raises SERR if SERR enabled.
// RL8: Bit 22 drives secondary bus reset directly.
// RL9: Secondary reset returns buffers and secondary logic to reset.
// RL10: Secondary reset leaves primary logic and configuration alone.
// RL11: Bit 23 gates fast back-to-back on secondary bus.
// RL12: Time-out counter starts when completion reaches queue head.
// RL13: Initiator must retry before expiry, else transaction discarded.
// RL14: Bit 24 selects 2^15 cycles when clear, 2^10 when set.
// RL15: VGA enable forwards memory window A0000 to BFFFF downstream.
// RL16: VGA enable forwards legacy video I/O register ranges.
// RL17: Time-out status set on discard, write one clears.
// RL18: Counter reloads on retry and clears on primary reset.
`include "bcu_map.svh"
module bcu_bridge_ctrl
    import bcu_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        primValid,
    input  wire logic        primIsIo,
    input  wire logic [31:0] primAddr,
    input  wire logic        secValid,
    input  wire logic        secIsIo,
    input  wire logic [31:0] secAddr,
    output logic             fwdDown,
    output logic             claimUp,
    input  wire logic        maDelayed,
    input  wire logic        maPosted,
    output logic             daTargetAbort,
    output logic             daAllOnes,
    output logic             primSerr,
    output logic             secBusReset,
    output logic             secLogicReset,
    output logic             fastB2bAllow,
    input  wire logic        dcHeadValid,
    input  wire logic        dcRetry,
    output logic             dcDiscard
);
    bcu_regs_t r_r;
    bcu_regs_t r_nxt;
    logic      toExpired;

    // Legacy video I/O range test on the low ten bits
    function automatic logic vgaIoHit(input logic [31:0] a);
        logic [9:0] lo;
        lo = a[9:0];
        // RL1 upper bits zero
        // RL16 video register ranges
        return (a[31:16] == 16'h0000) &&
               ((lo >= `BCU_VGA_IO1_LO && lo <= `BCU_VGA_IO1_HI) ||
                (lo >= `BCU_VGA_IO2_LO && lo <= `BCU_VGA_IO2_HI));
    endfunction : vgaIoHit

    // Legacy video memory window test
    function automatic logic vgaMemHit(input logic [31:0] a);
        // RL15 memory window
        return (a >= `BCU_VGA_MEM_LO) && (a <= `BCU_VGA_MEM_HI);
    endfunction : vgaMemHit

    // Byte-lane merge of a masked write
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [31:0] wm);
        logic [31:0] lanes;
        lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~(lanes & wm)) | (wd & lanes & wm);
    endfunction : merge

    bcu_timeout u_timeout (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .headValid (dcHeadValid),
        .retrySeen (dcRetry),
        .shortSel  (r_r.ctrl[`BCU_BIT_PTOSEL]),
        .expired   (toExpired)
    );

    // Slave answers a read one cycle after it is taken
    assign avs_waitrequest = avs_read && !r_r.readValid;
    assign avs_readdata    = r_r.readData;
    assign irq             = |(r_r.irqStat & r_r.irqMask);
    assign fwdDown         = r_r.fwdDown;
    assign claimUp         = r_r.claimUp;
    assign daTargetAbort   = r_r.daTargetAbort;
    assign daAllOnes       = r_r.daAllOnes;
    assign primSerr        = r_r.primSerr;
    // RL8 reset pin from bit
    assign secBusReset     = r_r.ctrl[`BCU_BIT_SECRST];
    // RL9 secondary logic reset
    assign secLogicReset   = r_r.ctrl[`BCU_BIT_SECRST];
    // RL11 fast back-to-back gate
    assign fastB2bAllow    = r_r.ctrl[`BCU_BIT_FB2B] &&
                             !r_r.ctrl[`BCU_BIT_SECRST];
    // RL13 discard on expiry
    assign dcDiscard       = toExpired;

    // Register file, decode and abort policy
    always_comb begin
        logic vgaOn;
        logic enBoth;
        logic rdClr;
        vgaOn  = 1'b0;
        enBoth = 1'b0;
        rdClr  = 1'b0;
        r_nxt  = r_r;
        vgaOn  = r_r.ctrl[`BCU_BIT_VGA];
        // RL2 both space enables
        enBoth = r_r.cmd[`BCU_BIT_IOEN] && r_r.cmd[`BCU_BIT_MEMEN];

        // Read data captured; waitrequest drops the next cycle
        r_nxt.readValid = avs_read && !r_r.readValid;
        if (avs_read && !r_r.readValid) begin
            unique case (avs_address)
                // RL4 reserved bit zero
                `BCU_OFF_CTRL: begin
                    r_nxt.readData = r_r.ctrl;
                    r_nxt.readData[`BCU_BIT_TOSTAT] = r_r.toStatus;
                end
                `BCU_OFF_CMD:     r_nxt.readData = r_r.cmd;
                `BCU_OFF_IRQSTAT: begin
                    r_nxt.readData = {30'h0, r_r.irqStat};
                    rdClr = 1'b1;
                end
                `BCU_OFF_IRQMASK: r_nxt.readData = {30'h0, r_r.irqMask};
                `BCU_OFF_STATUS:
                    r_nxt.readData = {29'h0, toExpired,
                                      dcHeadValid, r_r.toStatus};
                default:          r_nxt.readData = 32'h0000_0000;
            endcase
        end

        // Writes are taken in one cycle; RL10 config untouched by sec reset
        if (rdClr) begin
            r_nxt.irqStat = 2'b00;
        end
        if (avs_write) begin
            unique case (avs_address)
                `BCU_OFF_CTRL: begin
                    // RL4 writes ignored
                    r_nxt.ctrl = merge(r_r.ctrl, avs_writedata,
                                       avs_byteenable, `BCU_CTRL_WMASK);
                    // RL17 write one clears
                    if (avs_byteenable[3] &&
                        avs_writedata[`BCU_BIT_TOSTAT]) begin
                        r_nxt.toStatus = 1'b0;
                    end
                end
                `BCU_OFF_CMD:
                    r_nxt.cmd = merge(r_r.cmd, avs_writedata,
                                      avs_byteenable, `BCU_CMD_WMASK);
                `BCU_OFF_IRQMASK:
                    if (avs_byteenable[0]) begin
                        r_nxt.irqMask = avs_writedata[1:0];
                    end
                default: ;
            endcase
        end

        // Hardware set wins over clear
        // RL17 status on discard
        if (toExpired) begin
            r_nxt.toStatus = 1'b1;
            r_nxt.irqStat[`BCU_IRQ_TIMEOUT] = 1'b1;
        end
        if (maDelayed || maPosted) begin
            r_nxt.irqStat[`BCU_IRQ_MABORT] = 1'b1;
        end

        // RL1 RL15 RL16 VGA downstream decode
        r_nxt.fwdDown = primValid && vgaOn && enBoth &&
                        (primIsIo ? vgaIoHit(primAddr)
                                  : vgaMemHit(primAddr));
        // RL3 no upstream claim; ISA and window decode lie elsewhere
        r_nxt.claimUp = secValid && !r_r.ctrl[`BCU_BIT_SECRST] &&
                        !(vgaOn && (secIsIo ? vgaIoHit(secAddr)
                                            : vgaMemHit(secAddr)));

        // RL5 normal completion with all ones
        r_nxt.daAllOnes     = maDelayed && !r_r.ctrl[`BCU_BIT_MABORT];
        // RL6 target abort
        r_nxt.daTargetAbort = maDelayed && r_r.ctrl[`BCU_BIT_MABORT];
        // RL7 SERR on posted abort
        r_nxt.primSerr      = maPosted && r_r.ctrl[`BCU_BIT_MABORT] &&
                              r_r.cmd[`BCU_BIT_SERREN];
    end

    // Primary reset only; secondary reset never touches this state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_r <= '0;
        end else begin
            r_r <= r_nxt;
        end
    end
endmodule : bcu_bridge_ctrl

/* File: testbench/bcu_far_model.sv */
// Primary initiator model that keeps a completion queued and retries it
module bcu_far_model (
    input  wire logic        sys_clk,
    input  wire logic        headOn,
    input  wire logic [15:0] retryGap,
    output logic             dcHeadValid,
    output logic             dcRetry
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] gapCnt;
    always @(posedge sys_clk) begin
        dcHeadValid <= headOn;
        if (headOn && retryGap != 16'h0000 && gapCnt == retryGap) begin
            dcRetry <= 1'h1;
            gapCnt  <= 16'h0000;
        end else begin
            dcRetry <= 1'h0;
            gapCnt  <= headOn ? gapCnt + 16'h0001 : 16'h0000;
        end
    end
endmodule : bcu_far_model

/* File: testbench/bcu_bridge_ctrl_props.sv */
// Port-level checks for the bridge control block
module bcu_bridge_ctrl_props (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic primValid,
    input wire logic secValid,
    input wire logic fwdDown,
    input wire logic claimUp,
    input wire logic maDelayed,
    input wire logic maPosted,
    input wire logic daTargetAbort,
    input wire logic daAllOnes,
    input wire logic primSerr,
    input wire logic secBusReset,
    input wire logic secLogicReset,
    input wire logic fastB2bAllow,
    input wire logic dcHeadValid,
    input wire logic dcRetry,
    input wire logic dcDiscard
);
    logic [15:0] waitCnt_r;
    // Cycles the queued completion has waited without a retry
    always_ff @(posedge sys_clk) begin
        if (sys_rst || dcRetry || !dcHeadValid) begin
            waitCnt_r <= 16'h0000;
        end else if (waitCnt_r != 16'hFFFF) begin
            waitCnt_r <= waitCnt_r + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_secHeld; !$past(secBusReset) && $past(secValid); endsequence
    a_fwd_cause: assert property (fwdDown |-> $past(primValid))
        else $error("forward without primary request");
    a_claim_cause: assert property (claimUp |-> s_secHeld)
        else $error("upstream claim without cause");
    a_ones_cause: assert property (daAllOnes |-> $past(maDelayed))
        else $error("all ones without delayed abort");
    a_tabort_cause: assert property (daTargetAbort |-> $past(maDelayed) && !daAllOnes)
        else $error("both abort answers at once");
    a_serr_cause: assert property (primSerr |-> $past(maPosted))
        else $error("system error without posted abort");
    a_reset_pair: assert property (secBusReset == secLogicReset)
        else $error("secondary resets disagree");
    a_fb2b_gate: assert property (fastB2bAllow |-> !secBusReset)
        else $error("fast back-to-back during reset");
    a_discard_late: assert property (dcDiscard |-> waitCnt_r >= 16'd1000)
        else $error("discard before the time-out");
    a_discard_head: assert property (dcDiscard |-> $past(dcHeadValid))
        else $error("discard without queued completion");
endmodule : bcu_bridge_ctrl_props
bind bcu_bridge_ctrl bcu_bridge_ctrl_props i_props (.sys_clk, .sys_rst,
    .primValid, .secValid, .fwdDown, .claimUp, .maDelayed, .maPosted,
    .daTargetAbort, .daAllOnes, .primSerr, .secBusReset, .secLogicReset,
    .fastB2bAllow, .dcHeadValid, .dcRetry, .dcDiscard);

/* File: testbench/bcu_bridge_ctrl_test.sv */
// Self-checking bench for the bridge control block
`include "bcu_map.svh"
module bcu_bridge_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic primValid = 0, primIsIo = 0, secValid = 0, secIsIo = 0;
    logic maDelayed = 0, maPosted = 0, headOn = 0, waitQ = 1;
    logic [3:0] avs_address = 0;
    logic [31:0] avs_writedata = 0, primAddr = 0, secAddr = 0, rdQ, q;
    logic [15:0] retryGap = 0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, fwdDown, claimUp, daTargetAbort, daAllOnes;
    logic primSerr, secBusReset, secLogicReset, fastB2bAllow;
    logic dcHeadValid, dcRetry, dcDiscard;
    int bad_count = 0, n_checks = 0, cyc = 0, discN = 0, n;
    always #2 sys_clk = ~sys_clk;
    bcu_bridge_ctrl i_bcu_bridge_ctrl (.sys_clk, .sys_rst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hF),
        .avs_readdata, .avs_waitrequest, .irq, .primValid, .primIsIo,
        .primAddr, .secValid, .secIsIo, .secAddr, .fwdDown, .claimUp,
        .maDelayed, .maPosted, .daTargetAbort, .daAllOnes, .primSerr,
        .secBusReset, .secLogicReset, .fastB2bAllow, .dcHeadValid,
        .dcRetry, .dcDiscard);
    bcu_far_model i_bcu_far_model (.sys_clk, .headOn, .retryGap,
        .dcHeadValid, .dcRetry);
    // Mid-cycle copies avoid racing the design at the edge
    always @(negedge sys_clk) begin
        waitQ = avs_waitrequest;
        rdQ = avs_readdata;
        if (dcDiscard) discN++;
    end
    // Ceiling covers both time-out lengths with margin
    always @(posedge sys_clk) if (++cyc == 50000) begin
        bad_count++;
        complete_run();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon access held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        avs_write <= wr;
        avs_read <= !wr;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge sys_clk); while (waitQ);
        q = rdQ;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        #1;
    endtask : bus
    task automatic dec(input logic io, input logic [31:0] a,
                       input logic sv, input logic exp);
        @(posedge sys_clk);
        primValid <= !sv;
        secValid <= sv;
        primIsIo <= io;
        secIsIo <= io;
        primAddr <= a;
        secAddr <= a;
        @(posedge sys_clk);
        primValid <= 1'h0;
        secValid <= 1'h0;
        #1 chk(32'(sv ? claimUp : fwdDown), 32'(exp));
    endtask : dec
    // Abort on delayed (d=1) or posted cycle; exp is serr, tabort, ones
    task automatic abt(input logic d, input logic [31:0] exp);
        @(posedge sys_clk);
        maDelayed <= d;
        maPosted <= !d;
        @(posedge sys_clk);
        maDelayed <= 1'h0;
        maPosted <= 1'h0;
        #1 chk(32'({primSerr, daTargetAbort, daAllOnes}), exp);
    endtask : abt
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'h0;
        bus(0, `BCU_OFF_CTRL, 0);
        chk(q, 32'h0000_0000);
        bus(1, `BCU_OFF_CTRL, 32'hF1F8_0000);
        bus(0, `BCU_OFF_CTRL, 0);
        chk(q, 32'h01E8_0000);
        chk(32'({secBusReset, fastB2bAllow}), 32'h0000_0002);
        chk(32'(secLogicReset), 32'h0000_0001);
        bus(1, `BCU_OFF_CMD, 32'h0000_0103);
        bus(0, `BCU_OFF_CMD, 0);
        chk(q, 32'h0000_0103);
        bus(1, `BCU_OFF_CTRL, 32'h0188_0000);
        chk(32'({secBusReset, fastB2bAllow}), 32'h0000_0001);
        dec(0, 32'h000A_0000, 0, 1);
        dec(0, 32'h000C_0000, 0, 0);
        dec(1, 32'h0000_FFB0, 0, 1);
        dec(1, 32'h0001_03B0, 0, 0);
        dec(1, 32'h0000_03DF, 0, 1);
        dec(1, 32'h0000_03BC, 0, 0);
        dec(1, 32'h0000_03C0, 1, 0);
        dec(1, 32'h0000_1000, 1, 1);
        bus(1, `BCU_OFF_CMD, 32'h0000_0101);
        dec(1, 32'h0000_03B0, 0, 0);
        abt(1, 32'h0000_0001);
        abt(0, 32'h0000_0000);
        bus(1, `BCU_OFF_CTRL, 32'h01A8_0000);
        abt(1, 32'h0000_0002);
        abt(0, 32'h0000_0004);
        bus(1, `BCU_OFF_IRQMASK, 32'h0000_0003);
        @(posedge sys_clk);
        headOn <= 1'h1;
        retryGap <= 16'd500;
        repeat (2500) @(posedge sys_clk);
        chk(32'(discN), 0);
        headOn <= 1'h0;
        @(posedge sys_clk);
        headOn <= 1'h1;
        retryGap <= 16'h0000;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (discN == 0);
        chk(32'(n >= 1024 && n <= 1040), 1);
        @(posedge sys_clk);
        headOn <= 1'h0;
        @(posedge sys_clk);
        chk(32'(irq), 1);
        bus(1, `BCU_OFF_IRQMASK, 0);
        chk(32'(irq), 0);
        // Both events pending: time-out and the earlier aborts
        bus(0, `BCU_OFF_IRQSTAT, 0);
        chk(q, 32'h0000_0003);
        bus(0, `BCU_OFF_IRQSTAT, 0);
        chk(q, 32'h0000_0000);
        bus(0, `BCU_OFF_CTRL, 0);
        chk(q, 32'h05A8_0000);
        bus(1, `BCU_OFF_CTRL, 32'h05A8_0000);
        bus(0, `BCU_OFF_CTRL, 0);
        chk(q, 32'h01A8_0000);
        bus(0, 4'hF, 0);
        chk(q, 32'h0000_0000);
        // Long time-out with select bit clear, no retries
        bus(1, `BCU_OFF_CTRL, 32'h00A8_0000);
        @(posedge sys_clk);
        headOn <= 1'h1;
        n = 0;
        do begin @(negedge sys_clk); n++; end while (discN == 1);
        chk(32'(n >= 32768 && n <= 32784), 1);
        @(posedge sys_clk);
        headOn <= 1'h0;
        complete_run();
    end
endmodule : bcu_bridge_ctrl_test
